// File: verilog/cif_pkg.sv
// Constants and types shared by the CRC input FIFO and shift feed.
package cif_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int CIF_ADDR_W = 2;
    localparam int CIF_DATA_W = 16;
    localparam logic [1:0] CIF_ADDR_CTRL1 = 2'h0;
    localparam logic [1:0] CIF_ADDR_CTRL2 = 2'h1;
    localparam logic [1:0] CIF_ADDR_DATL = 2'h2;
    localparam logic [1:0] CIF_ADDR_DATH = 2'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CIF_C1_EN_BIT = 0;
    localparam int CIF_C1_LSB_BIT = 3;
    localparam int CIF_C1_RUN_BIT = 4;
    localparam int CIF_C1_EMPTY_BIT = 6;
    localparam int CIF_C1_FULL_BIT = 7;
    localparam int CIF_C1_CNT_LSB = 8;
    localparam int CIF_C2_WIDTH_LSB = 8;

    // ------------------------------------------------------------
    // Sizes, thresholds and reset values
    // ------------------------------------------------------------
    localparam int CIF_WF_W = 5;
    localparam int CIF_CNT_W = 5;
    localparam int CIF_PTR_W = 4;
    localparam int CIF_DEPTH = 16;
    localparam int CIF_ENTRY_W = 32;
    localparam logic [4:0] CIF_W_BYTE_MAX = 5'h07;
    localparam logic [4:0] CIF_W_HALF_MAX = 5'h0f;
    localparam logic [4:0] CIF_CAP_BYTE = 5'h10;
    localparam logic [4:0] CIF_CAP_HALF = 5'h08;
    localparam logic [4:0] CIF_CAP_WORD = 5'h04;
    localparam logic [3:0] CIF_MASK_BYTE = 4'hf;
    localparam logic [3:0] CIF_MASK_HALF = 4'h7;
    localparam logic [3:0] CIF_MASK_WORD = 4'h3;
    localparam logic [4:0] CIF_WF_RST = 5'h00;
    localparam logic [4:0] CIF_TOP_BIT = 5'h1f;
    localparam logic [1:0] CIF_XFER_CYC = 2'h2;
    localparam logic [5:0] CIF_BITS_PER_CYC = 6'h02;

    // ------------------------------------------------------------
    // Feed sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CIF_IDLE = 2'b00,
        CIF_XFER = 2'b01,
        CIF_SHIFT = 2'b10
    } cif_state_t;

endpackage : cif_pkg

// File: verilog/cif_feed.sv
// CRC input FIFO with variable element width and feed to the shift engine.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns

module cif_feed (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [cif_pkg::CIF_ADDR_W-1:0] reg_addr,
    input wire logic [cif_pkg::CIF_DATA_W-1:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cif_pkg::CIF_DATA_W-1:0] reg_rdata,
    // Shift engine feed
    output logic eng_bit_first,
    output logic eng_bit_second,
    output logic [1:0] eng_bit_count,
    output logic eng_busy,
    // Status
    output logic queue_full_flag,
    output logic queue_empty_flag
);
    import cif_pkg::*;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic module_enable_r;
    logic lsb_first_select_r;
    logic shift_run_enable_r;
    logic [CIF_WF_W-1:0] input_width_field_r;
    logic [CIF_DATA_W-1:0] low_hold_r;

    wire wr_c1 = reg_wr && (reg_addr == CIF_ADDR_CTRL1);
    wire wr_c2 = reg_wr && (reg_addr == CIF_ADDR_CTRL2);
    wire wr_datl = reg_wr && (reg_addr == CIF_ADDR_DATL);
    wire wr_dath = reg_wr && (reg_addr == CIF_ADDR_DATH);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            module_enable_r <= 1'b0;
            lsb_first_select_r <= 1'b0;
            shift_run_enable_r <= 1'b0;
        end else if (wr_c1 && reg_be[0]) begin
            module_enable_r <= reg_wdata[CIF_C1_EN_BIT];
            lsb_first_select_r <= reg_wdata[CIF_C1_LSB_BIT];
            shift_run_enable_r <= reg_wdata[CIF_C1_RUN_BIT];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            input_width_field_r <= CIF_WF_RST;
        end else if (wr_c2 && reg_be[1]) begin
            input_width_field_r <=
                reg_wdata[CIF_C2_WIDTH_LSB +: CIF_WF_W];
        end
    end

    // ------------------------------------------------------------
    // Width mode and capacity
    // ------------------------------------------------------------
    // The width field selects one of three storage modes. Narrow elements
    // take one byte lane each, medium elements one low-port word, and
    // wide elements a low and a high word together.
    // The capacity and the pointer wrap mask follow the current width.
    // Software must only change the width while the queue is empty and
    // the sequencer is idle; otherwise stored entries are read back with
    // the wrong length and the pointers may wrap at the wrong depth.
    // Nothing here guards against that misuse.
    wire mode_byte = (input_width_field_r <= CIF_W_BYTE_MAX);
    wire mode_half = !mode_byte && (input_width_field_r <= CIF_W_HALF_MAX);
    wire mode_word = !mode_byte && !mode_half;

    wire [CIF_CNT_W-1:0] capacity = mode_byte ? CIF_CAP_BYTE :
        (mode_half ? CIF_CAP_HALF : CIF_CAP_WORD);
    wire [CIF_PTR_W-1:0] ptr_mask = mode_byte ? CIF_MASK_BYTE :
        (mode_half ? CIF_MASK_HALF : CIF_MASK_WORD);

    // ------------------------------------------------------------
    // Push decode
    // ------------------------------------------------------------
    logic [CIF_CNT_W-1:0] count_r;
    logic [CIF_PTR_W-1:0] wp_r;
    logic [CIF_PTR_W-1:0] rp_r;

    wire full_now = (count_r >= capacity);
    wire [CIF_CNT_W-1:0] space = capacity - count_r;
    wire room_two = (space > 5'h01);

    // Narrow mode: every written byte is its own entry, low lane first.
    // When only one slot is free, a full word write keeps its low byte
    // and the high byte is dropped, exactly as if it had come while full.
    // Writes to the high port only matter in wide mode; in the other
    // modes they decode to nothing and the queue is left alone.
    wire lo_req = mode_byte && wr_datl && reg_be[0];
    wire hi_req = mode_byte && wr_datl && reg_be[1];
    wire byte_a = lo_req || hi_req;
    wire byte_b = lo_req && hi_req && room_two;
    wire [7:0] byte_a_val = lo_req ? reg_wdata[7:0] : reg_wdata[15:8];

    wire half_push = mode_half && wr_datl;
    wire word_push = mode_word && wr_dath;

    wire push_a = !full_now && (byte_a || half_push || word_push);
    wire push_b = !full_now && byte_b;

    // Byte data is stored whole; only the low width bits are ever shifted.
    wire [CIF_ENTRY_W-1:0] data_a = byte_a ? {24'h000000, byte_a_val} :
        (half_push ? {16'h0000, reg_wdata} :
        {reg_wdata, low_hold_r});
    wire [CIF_ENTRY_W-1:0] data_b = {24'h000000, reg_wdata[15:8]};

    wire [CIF_PTR_W-1:0] wp_b = (wp_r + 4'h1) & ptr_mask;

    // The low half of a wide element waits here for its high half.
    // It is not latched while the queue is full, so a refused pair
    // leaves the previously accepted low half in place. A high write
    // with no fresh low write reuses that held value.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            low_hold_r <= 16'h0000;
        end else if (mode_word && wr_datl && !full_now) begin
            low_hold_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Storage, one entry per generate slot
    // ------------------------------------------------------------
    // Every slot is a full element wide, whatever the mode. Only the
    // lower part of the array is used in the wider-element modes, since
    // the pointer mask wraps early there.
    // The storage has no reset: the counters alone say which slots hold
    // data, so stale contents are never shifted out.
    logic [CIF_ENTRY_W-1:0] mem [CIF_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < CIF_DEPTH; gi++) begin : g_entry
            wire sel_a = push_a && (wp_r == CIF_PTR_W'(gi));
            wire sel_b = push_b && (wp_b == CIF_PTR_W'(gi));
            always_ff @(posedge mclk) begin
                if (sel_a) begin
                    mem[gi] <= data_a;
                end else if (sel_b) begin
                    mem[gi] <= data_b;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Feed sequencer
    // ------------------------------------------------------------
    // The sequencer leaves idle once run is set and an entry waits. It
    // then spends two cycles moving the oldest entry into the shift
    // buffer; the count drops at the end of the second cycle. After
    // that the buffer is emptied two bits per cycle. If another entry is
    // waiting when the last bits go out, the next transfer starts at
    // once, with no idle cycle in between.
    // Clearing run freezes the state, the transfer counter and the shift
    // buffer where they stand, so a later run resumes with no bit lost.
    // Clearing the enable returns the sequencer to idle and drops any
    // partly shifted entry.
    cif_state_t state_r;
    cif_state_t state_nxt;
    logic [1:0] xfer_cnt_r;
    logic [CIF_ENTRY_W-1:0] sbuf_r;
    logic [5:0] bits_left_r;
    logic dir_lsb_r;

    wire go = module_enable_r && shift_run_enable_r;
    wire have_entry = (count_r != 5'h00);
    wire xfer_last = (xfer_cnt_r == CIF_XFER_CYC - 2'h1);
    wire shift_last = (bits_left_r <= CIF_BITS_PER_CYC);
    wire pop = go && (state_r == CIF_XFER) && xfer_last;
    wire [CIF_ENTRY_W-1:0] pop_data = mem[rp_r];
    wire [4:0] align = CIF_TOP_BIT - input_width_field_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CIF_IDLE: begin
                if (go && have_entry) begin
                    state_nxt = CIF_XFER;
                end
            end
            CIF_XFER: begin
                if (pop) begin
                    state_nxt = CIF_SHIFT;
                end
            end
            CIF_SHIFT: begin
                if (go && shift_last) begin
                    state_nxt = have_entry ? CIF_XFER : CIF_IDLE;
                end
            end
            default: begin
                state_nxt = CIF_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= CIF_IDLE;
            xfer_cnt_r <= 2'h0;
        end else if (!module_enable_r) begin
            state_r <= CIF_IDLE;
            xfer_cnt_r <= 2'h0;
        end else if (go) begin
            state_r <= state_nxt;
            xfer_cnt_r <= (state_nxt == CIF_XFER && state_r == CIF_XFER) ?
                xfer_cnt_r + 2'h1 : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Shift buffer, two bits per cycle
    // ------------------------------------------------------------
    // The bit order is taken when an entry loads, so a change of the
    // order select affects only entries that load after it.
    // For an odd element length the last cycle carries a single bit and
    // the second engine bit is then held low.
    // The engine outputs are registered, so every bit reaches the engine
    // one cycle after the sequencer produces it.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sbuf_r <= 32'h00000000;
            bits_left_r <= 6'h00;
            dir_lsb_r <= 1'b0;
        end else if (pop) begin
            // MSB-first data is left aligned so bit 31 leads.
            sbuf_r <= lsb_first_select_r ? pop_data : (pop_data << align);
            bits_left_r <= {1'b0, input_width_field_r} + 6'h01;
            dir_lsb_r <= lsb_first_select_r;
        end else if (go && state_r == CIF_SHIFT) begin
            sbuf_r <= dir_lsb_r ? (sbuf_r >> 2) : (sbuf_r << 2);
            bits_left_r <= shift_last ? 6'h00 :
                bits_left_r - CIF_BITS_PER_CYC;
        end
    end

    wire emit = go && (state_r == CIF_SHIFT);
    wire [1:0] emit_n = !emit ? 2'h0 :
        (bits_left_r == 6'h01 ? 2'h1 : 2'h2);
    wire bit_one = dir_lsb_r ? sbuf_r[0] : sbuf_r[31];
    wire bit_two = (emit_n == 2'h2) ?
        (dir_lsb_r ? sbuf_r[1] : sbuf_r[30]) : 1'b0;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            eng_bit_first <= 1'b0;
            eng_bit_second <= 1'b0;
            eng_bit_count <= 2'h0;
            eng_busy <= 1'b0;
        end else begin
            eng_bit_first <= emit ? bit_one : 1'b0;
            eng_bit_second <= bit_two;
            eng_bit_count <= emit_n;
            eng_busy <= module_enable_r && (state_nxt != CIF_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Pointers, count and flags
    // ------------------------------------------------------------
    // The flags are worked out from the next count, so they change on
    // the same edge as the count they describe and never lag it.
    // While the block is disabled the queue is held empty on every
    // cycle, which discards any entry pushed in that time; a wide-mode low half written then is still latched into low_hold_r.
    // Pushes and pops are counted in the same cycle, so writes can keep
    // arriving while the sequencer drains entries into the shift buffer.
    // A byte-mode word write can add two entries at once; a pop can only
    // ever remove one, because each transfer takes two cycles.
    // A pop never frees room for a write in the same cycle: the full test
    // looks at the registered count, so a write on a full queue is lost
    // even when the sequencer is taking an entry at that very edge.
    wire [CIF_CNT_W-1:0] push_n = {4'h0, push_a} + {4'h0, push_b};
    wire [CIF_CNT_W-1:0] count_nxt = count_r + push_n -
        {4'h0, pop};
    wire [CIF_PTR_W-1:0] wp_nxt = (wp_r + push_n[CIF_PTR_W-1:0]) & ptr_mask;
    wire [CIF_PTR_W-1:0] rp_nxt = (rp_r + {3'h0, pop}) & ptr_mask;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_r <= 5'h00;
            wp_r <= 4'h0;
            rp_r <= 4'h0;
            queue_full_flag <= 1'b0;
            queue_empty_flag <= 1'b1;
        end else if (!module_enable_r) begin
            count_r <= 5'h00;
            wp_r <= 4'h0;
            rp_r <= 4'h0;
            queue_full_flag <= 1'b0;
            queue_empty_flag <= 1'b1;
        end else begin
            count_r <= count_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            queue_full_flag <= (count_nxt >= capacity);
            queue_empty_flag <= (count_nxt == 5'h00);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [CIF_DATA_W-1:0] c1_view;
    logic [CIF_DATA_W-1:0] c2_view;
    logic [CIF_DATA_W-1:0] rd_sel;

    always_comb begin
        c1_view = 16'h0000;
        c1_view[CIF_C1_EN_BIT] = module_enable_r;
        c1_view[CIF_C1_LSB_BIT] = lsb_first_select_r;
        c1_view[CIF_C1_RUN_BIT] = shift_run_enable_r;
        c1_view[CIF_C1_EMPTY_BIT] = queue_empty_flag;
        c1_view[CIF_C1_FULL_BIT] = queue_full_flag;
        c1_view[CIF_C1_CNT_LSB +: CIF_CNT_W] = count_r;
        c2_view = 16'h0000;
        c2_view[CIF_C2_WIDTH_LSB +: CIF_WF_W] = input_width_field_r;
    end

    // Data ports are write only and read back as zero.
    // The read data are zero in every cycle that does not follow a read,
    // so a consumer may simply sample them one cycle after its strobe.
    assign rd_sel = (reg_addr == CIF_ADDR_CTRL1) ? c1_view :
        ((reg_addr == CIF_ADDR_CTRL2) ? c2_view : 16'h0000);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_sel : 16'h0000;
        end
    end

endmodule : cif_feed

// File: sim/cif_feed_properties.sv
// Port checker for the CRC input FIFO feed.
`timescale 1ns/1ns
module cif_feed_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [cif_pkg::CIF_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [cif_pkg::CIF_DATA_W-1:0] reg_rdata,
    // Feed and status
    input wire logic eng_bit_second,
    input wire logic [1:0] eng_bit_count,
    input wire logic eng_busy,
    input wire logic queue_full_flag,
    input wire logic queue_empty_flag
);
    import cif_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    port_read_a: assert property (
        reg_rd && reg_addr[1] |=> reg_rdata == 16'h0)
        else $error("data port read not zero");
    rdata_quiet_a: assert property (
        !reg_rd |=> reg_rdata == 16'h0)
        else $error("read data without read");
    status_read_a: assert property (
        reg_rd && reg_addr == CIF_ADDR_CTRL1 |=>
        reg_rdata[7:6] == $past({queue_full_flag, queue_empty_flag}))
        else $error("status bits differ from flags");
    flag_excl_a: assert property (
        !(queue_full_flag && queue_empty_flag))
        else $error("full and empty together");
    full_cause_a: assert property (
        $rose(queue_full_flag) |-> $past(reg_wr))
        else $error("full rose without write");
    empty_cause_a: assert property (
        $fell(queue_empty_flag) |-> $past(reg_wr))
        else $error("empty fell without write");
    second_bit_a: assert property (
        eng_bit_count != 2'h2 |-> !eng_bit_second)
        else $error("second bit set without two bits");
    bit_count_a: assert property (
        eng_bit_count != 2'h3)
        else $error("more than two bits per cycle");
    xfer_gap_a: assert property (
        $fell(queue_empty_flag) && !eng_busy && eng_bit_count == 2'h0
        |-> eng_bit_count == 2'h0 [*3])
        else $error("bits before transfer done");
endmodule : cif_feed_properties

bind cif_feed cif_feed_properties chk_u (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_bit_second(eng_bit_second),
    .eng_bit_count(eng_bit_count), .eng_busy(eng_busy),
    .queue_full_flag(queue_full_flag), .queue_empty_flag(queue_empty_flag)
);

// File: sim/cif_feed_tb.sv
// Self-checking bench for the CRC input FIFO and shift feed.
`timescale 1ns/1ns
module cif_feed_tb;
    import cif_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [1:0] reg_be = 2'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] eng_bit_count;
    logic eng_bit_first, eng_bit_second, eng_busy;
    logic queue_full_flag, queue_empty_flag;
    logic [4:0] wf = 5'h05;
    logic [4:0] wlist[7] = '{5'h00, 5'h05, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h1f};
    logic lsb = 1'b0;
    int room = 1;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 32'h365b;
    bit exp_q[$];
    bit got_q[$];

    always #50 mclk = ~mclk;

    cif_feed dut_u (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .eng_bit_first(eng_bit_first),
        .eng_bit_second(eng_bit_second), .eng_bit_count(eng_bit_count),
        .eng_busy(eng_busy), .queue_full_flag(queue_full_flag),
        .queue_empty_flag(queue_empty_flag)
    );

    // Collects every bit handed to the shift engine.
    always @(posedge mclk) begin
        if (!reset && eng_bit_count != 2'h0) got_q.push_back(eng_bit_first);
        if (!reset && eng_bit_count == 2'h2) got_q.push_back(eng_bit_second);
    end

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check16(string what, logic [15:0] got, logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check16

    task automatic wr(logic [1:0] a, logic [15:0] d, logic [1:0] be);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd_chk(logic [1:0] a, logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check16("read", reg_rdata, exp);
        @(posedge mclk);
    endtask : rd_chk

    // Expected bit order of one accepted entry; excess pushes are dropped.
    function automatic void add(logic [31:0] e);
        if (room == 0) return;
        room--;
        for (int i = 0; i <= int'(wf); i++)
            exp_q.push_back(lsb ? e[i] : e[int'(wf) - i]);
    endfunction : add

    task automatic push(logic [31:0] d, logic [1:0] be);
        if (wf <= 5'h07) begin
            wr(CIF_ADDR_DATL, d[15:0], be);
            if (be[0]) add({24'h0, d[7:0]});
            if (be[1]) add({24'h0, d[15:8]});
        end else if (wf <= 5'h0f) begin
            wr(CIF_ADDR_DATH, d[31:16], 2'h3);
            wr(CIF_ADDR_DATL, d[15:0], 2'h3);
            add({16'h0, d[15:0]});
        end else begin
            wr(CIF_ADDR_DATL, d[15:0], 2'h3);
            wr(CIF_ADDR_DATH, d[31:16], 2'h3);
            add(d);
        end
    endtask : push

    // Waits for the feed to go idle, or for room in the FIFO.
    task automatic settle(bit idle);
        int n;
        n = 0;
        #1;
        while ((idle ? !(queue_empty_flag === 1'b1 && eng_busy === 1'b0)
                     : queue_full_flag !== 1'b0) && n < 500) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 500) begin
            n_errors++;
            $display("MISMATCH %0t wait timed out", $time);
            finish_test();
        end
        if (idle) repeat (4) @(posedge mclk);
    endtask : settle

    task automatic check_bits();
        check16("bit total", 16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size()) check16("bit", 16'(got_q[i]), 16'(exp_q[i]));
        exp_q.delete();
        got_q.delete();
    endtask : check_bits

    initial begin
        int h;
        logic [4:0] cap;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1 check16("flags", {14'h0, queue_full_flag, queue_empty_flag}, 16'h1);
        rd_chk(CIF_ADDR_CTRL1, 16'h0040);
        rd_chk(CIF_ADDR_CTRL2, 16'h0000);
        wr(CIF_ADDR_CTRL2, 16'h0500, 2'h3);
        wr(CIF_ADDR_CTRL1, 16'h0011, 2'h3);
        push({$random(seed)}, 2'h1);
        rd_chk(CIF_ADDR_CTRL1, 16'h0111);
        for (int k = 0; k < 4; k++) begin
            #1 check16("bits/cycle", {14'h0, eng_bit_count},
                       k > 0 ? 16'h2 : 16'h0);
            @(posedge mclk);
        end
        settle(1'b1);
        check_bits();
        foreach (wlist[j]) begin
            wf = wlist[j];
            lsb = 1'($random(seed));
            cap = wf <= 5'h07 ? 5'h10 : (wf <= 5'h0f ? 5'h08 : 5'h04);
            room = int'(cap);
            wr(CIF_ADDR_CTRL1, 16'h0001, 2'h3);
            wr(CIF_ADDR_CTRL2, {3'h0, wf, 8'h00}, 2'h3);
            while (room > 0)
                push({$random(seed)}, room > 1 ? 2'(1 + {$random(seed)} % 3) : 2'h1);
            rd_chk(CIF_ADDR_CTRL1, {3'h0, cap, 8'h81});
            push({$random(seed)}, 2'h3);
            rd_chk(CIF_ADDR_CTRL1, {3'h0, cap, 8'h81});
            rd_chk(CIF_ADDR_DATL, 16'h0000);
            rd_chk(CIF_ADDR_DATH, 16'h0000);
            wr(CIF_ADDR_CTRL1, {11'h0, 1'b1, lsb, 3'h1}, 2'h3);
            room = 99;
            repeat (6) begin
                settle(1'b0);
                push({$random(seed)}, 2'h1);
            end
            wr(CIF_ADDR_CTRL1, {11'h0, 1'b0, lsb, 3'h1}, 2'h3);
            repeat (5) @(posedge mclk);
            h = got_q.size();
            repeat (10) @(posedge mclk);
            check16("halted", 16'(got_q.size()), 16'(h));
            wr(CIF_ADDR_CTRL1, {11'h0, 1'b1, lsb, 3'h1}, 2'h3);
            settle(1'b1);
            check_bits();
            rd_chk(CIF_ADDR_CTRL1, {11'h0, 1'b1, lsb, 3'h1} | 16'h0040);
            wr(CIF_ADDR_CTRL1, 16'h0001, 2'h3);
            room = 0;
            push({$random(seed)}, 2'h1);
            wr(CIF_ADDR_CTRL1, 16'h0000, 2'h3);
            rd_chk(CIF_ADDR_CTRL1, 16'h0040);
        end
        finish_test();
    end
endmodule : cif_feed_tb
